// [rtl/rtcot_pkg.sv]
// constants shared by the output select and trim logic
package rtcot_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h07;
  localparam logic [7:0] ADDR_TRIM   = 8'h08;
  localparam logic [7:0] ADDR_ALM0WD = 8'h0d;
  localparam logic [7:0] ADDR_ALM1WD = 8'h14;

  // ==========================================================
  // output_and_trim_control fields
  localparam int CTRL_GPO_LVL = 7;
  localparam int CTRL_SQW_EN  = 6;
  localparam int CTRL_ALM1_EN = 5;
  localparam int CTRL_ALM0_EN = 4;
  localparam int CTRL_EXT_OSC = 3;
  localparam int CTRL_COARSE  = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // trim register fields
  localparam int TRIM_SIGN   = 7;
  localparam int TRIM_MAG_HI = 6;
  localparam int TRIM_MAG_LO = 0;
  localparam logic [7:0] TRIM_RESET = 8'h00;

  // alarm weekday and flags fields
  localparam int ALM_POL    = 7;
  localparam int ALM_SEL_HI = 6;
  localparam int ALM_SEL_LO = 4;
  localparam int ALM_FLAG   = 3;
  localparam int ALM_WD_HI  = 2;
  localparam int ALM_WD_LO  = 0;

  // ==========================================================
  // timebase
  localparam int OSC_HZ        = 32768;
  localparam int SEC_PER_MIN   = 60;
  localparam int CYCLES_PER_STEP = 2;
  localparam int COARSE_HZ     = 128;
  localparam int COARSE_DIV    = OSC_HZ / COARSE_HZ;
  localparam int COARSE_W      = $clog2(COARSE_DIV);
  localparam int TRIM_MAG_W    = 7;

  // square wave taps on the prescaler count
  localparam int TAP_4K   = 2;
  localparam int TAP_8K   = 1;
  localparam int TAP_64HZ = 8;

  localparam logic [1:0] RATE_1HZ  = 2'h0;
  localparam logic [1:0] RATE_4K   = 2'h1;
  localparam logic [1:0] RATE_8K   = 2'h2;
  localparam logic [1:0] RATE_32K  = 2'h3;

endpackage : rtcot_pkg

// [rtl/rtcot_trim.sv]
// oscillator prescaler with digital trim adjustment
`timescale 1ns/10ps
module rtcot_trim #(
  parameter int PRESCALE    = rtcot_pkg::OSC_HZ,
  parameter int SEC_PER_MIN = rtcot_pkg::SEC_PER_MIN,
  parameter int PW          = $clog2(PRESCALE)
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          osc_tick_i,
  input  wire logic          coarse_i,
  input  wire logic          add_i,
  input  wire logic [6:0]    trim_magnitude_i,
  output logic      [PW-1:0] prescale_o,
  output logic               sec_tick_o,
  output logic               trim_event_o
);

  localparam int SW = $clog2(SEC_PER_MIN);
  localparam int CW = rtcot_pkg::COARSE_W;

  logic [SW-1:0] sec_cnt_q;
  logic [CW-1:0] coarse_cnt_q;
  logic [8:0]    swallow_q;
  logic          pend_q;
  logic [7:0]    amount;
  logic          apply;
  logic [PW:0]   sum;
  logic          wrap;

  // ==========================================================
  // adjustment amount and event
  assign amount = 8'(trim_magnitude_i) * 8'(rtcot_pkg::CYCLES_PER_STEP);
  assign apply  = osc_tick_i && pend_q && (trim_magnitude_i != 7'h00);

  always_comb
  begin
    sum = (PW+1)'(prescale_o);
    if (swallow_q == 9'h000)
    begin
      sum = sum + (PW+1)'(1);
    end
    if (apply && add_i)
    begin
      sum = sum + (PW+1)'(amount);
    end
  end

  assign wrap = osc_tick_i && (sum >= (PW+1)'(PRESCALE));

  // ==========================================================
  // prescaler; cycles removed are swallowed from later ticks
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      prescale_o <= '0;
      swallow_q  <= 9'h000;
    end
    else if (osc_tick_i)
    begin
      prescale_o <= wrap ? PW'(sum - (PW+1)'(PRESCALE)) : PW'(sum);
      if (apply && !add_i)
      begin
        swallow_q <= swallow_q + 9'(amount);
      end
      else if (swallow_q != 9'h000)
      begin
        swallow_q <= swallow_q - 9'h001;
      end
    end
  end

  // ==========================================================
  // minute and coarse event scheduling
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sec_cnt_q    <= '0;
      coarse_cnt_q <= '0;
      pend_q       <= 1'b0;
    end
    else if (osc_tick_i)
    begin
      coarse_cnt_q <= coarse_cnt_q + CW'(1);
      if (wrap)
      begin
        sec_cnt_q <= (sec_cnt_q == SW'(SEC_PER_MIN - 1)) ? '0
                   : sec_cnt_q + SW'(1);
      end
      if (coarse_i)
      begin
        pend_q <= (coarse_cnt_q == '1);
      end
      else
      begin
        pend_q <= wrap && (sec_cnt_q == SW'(SEC_PER_MIN - 1));
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sec_tick_o   <= 1'b0;
      trim_event_o <= 1'b0;
    end
    else
    begin
      sec_tick_o   <= wrap;
      trim_event_o <= apply;
    end
  end

endmodule : rtcot_trim

// [rtl/rtcot_top.sv]
// output pin source selection, alarm flag registers and trim control
`timescale 1ns/10ps
module rtcot_top #(
  parameter int PRESCALE    = rtcot_pkg::OSC_HZ,
  parameter int SEC_PER_MIN = rtcot_pkg::SEC_PER_MIN
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       osc_tick_i,
  input  wire logic       osc_level_i,
  input  wire logic       on_backup_i,
  input  wire logic       alarm_zero_match_i,
  input  wire logic       alarm_one_match_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            multi_function_pin_o,
  output logic            multi_function_pin_oe_o,
  output logic            sec_tick_o,
  output logic            trim_event_o
);

  localparam int PW = $clog2(PRESCALE);

  logic [7:0]    ctrl_q;
  logic [7:0]    trim_q;
  logic          alarm_output_polarity_q;
  logic [2:0]    alarm_zero_match_select_q;
  logic [2:0]    alarm_one_match_select_q;
  logic [2:0]    alarm_zero_weekday_q;
  logic [2:0]    alarm_one_weekday_q;
  logic          alarm_zero_flag_q;
  logic          alarm_one_flag_q;
  logic [PW-1:0] prescale;
  logic          wr_ctrl;
  logic          wr_trim;
  logic          wr_alm0;
  logic          wr_alm1;
  logic          pin_level;
  logic          pin_driven;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == rtcot_pkg::ADDR_CTRL);
  assign wr_trim = reg_wr_i && (reg_addr_i == rtcot_pkg::ADDR_TRIM);
  assign wr_alm0 = reg_wr_i && (reg_addr_i == rtcot_pkg::ADDR_ALM0WD);
  assign wr_alm1 = reg_wr_i && (reg_addr_i == rtcot_pkg::ADDR_ALM1WD);

  // ==========================================================
  // helpers
  function automatic logic rtcot_alarm_level(input logic pol,
                                             input logic en0,
                                             input logic en1,
                                             input logic f0,
                                             input logic f1);
    logic lvl;
    lvl = 1'b0;
    if (en0 && en1)
    begin
      lvl = pol ? (f0 | f1) : ~(f0 & f1);
    end
    else if (en0)
    begin
      lvl = pol ? f0 : ~f0;
    end
    else
    begin
      lvl = pol ? f1 : ~f1;
    end
    return lvl;
  endfunction : rtcot_alarm_level

  function automatic logic rtcot_sqw_level(input logic [1:0]    rate,
                                           input logic          coarse,
                                           input logic [PW-1:0] cnt,
                                           input logic          osc);
    logic lvl;
    lvl = cnt[PW-1];
    if (coarse)
    begin
      lvl = cnt[rtcot_pkg::TAP_64HZ];
    end
    else
    begin
      unique case (rate)
        rtcot_pkg::RATE_1HZ: lvl = cnt[PW-1];
        rtcot_pkg::RATE_4K:  lvl = cnt[rtcot_pkg::TAP_4K];
        rtcot_pkg::RATE_8K:  lvl = cnt[rtcot_pkg::TAP_8K];
        rtcot_pkg::RATE_32K: lvl = osc;
      endcase
    end
    return lvl;
  endfunction : rtcot_sqw_level

  // ==========================================================
  // control and trim registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= rtcot_pkg::CTRL_RESET;
      trim_q <= rtcot_pkg::TRIM_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= reg_wdata_i;
      end
      if (wr_trim)
      begin
        trim_q <= reg_wdata_i;
      end
    end
  end

  // ==========================================================
  // alarm registers; a match wins over a clearing write
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      alarm_output_polarity_q   <= 1'b0;
      alarm_zero_match_select_q <= 3'h0;
      alarm_one_match_select_q  <= 3'h0;
      alarm_zero_weekday_q      <= 3'h0;
      alarm_one_weekday_q       <= 3'h0;
    end
    else
    begin
      if (wr_alm0 || wr_alm1)
      begin
        alarm_output_polarity_q <= reg_wdata_i[rtcot_pkg::ALM_POL];
      end
      if (wr_alm0)
      begin
        alarm_zero_match_select_q <=
          reg_wdata_i[rtcot_pkg::ALM_SEL_HI:rtcot_pkg::ALM_SEL_LO];
        alarm_zero_weekday_q <=
          reg_wdata_i[rtcot_pkg::ALM_WD_HI:rtcot_pkg::ALM_WD_LO];
      end
      if (wr_alm1)
      begin
        alarm_one_match_select_q <=
          reg_wdata_i[rtcot_pkg::ALM_SEL_HI:rtcot_pkg::ALM_SEL_LO];
        alarm_one_weekday_q <=
          reg_wdata_i[rtcot_pkg::ALM_WD_HI:rtcot_pkg::ALM_WD_LO];
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      alarm_zero_flag_q <= 1'b0;
      alarm_one_flag_q  <= 1'b0;
    end
    else
    begin
      alarm_zero_flag_q <= alarm_zero_match_i ||
        (wr_alm0 ? reg_wdata_i[rtcot_pkg::ALM_FLAG] : alarm_zero_flag_q);
      alarm_one_flag_q <= alarm_one_match_i ||
        (wr_alm1 ? reg_wdata_i[rtcot_pkg::ALM_FLAG] : alarm_one_flag_q);
    end
  end

  // ==========================================================
  // register read port
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        rtcot_pkg::ADDR_CTRL: reg_rdata_o <= ctrl_q;
        rtcot_pkg::ADDR_TRIM: reg_rdata_o <= trim_q;
        rtcot_pkg::ADDR_ALM0WD: reg_rdata_o <= {alarm_output_polarity_q,
          alarm_zero_match_select_q, alarm_zero_flag_q, alarm_zero_weekday_q};
        rtcot_pkg::ADDR_ALM1WD: reg_rdata_o <= {alarm_output_polarity_q,
          alarm_one_match_select_q, alarm_one_flag_q, alarm_one_weekday_q};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // trim engine, not gated by backup supply
  rtcot_trim #(
    .PRESCALE    (PRESCALE),
    .SEC_PER_MIN (SEC_PER_MIN)
  ) u_trim (
    .ref_clk_i        (ref_clk_i),
    .rst_n_i          (rst_n_i),
    .osc_tick_i       (osc_tick_i),
    .coarse_i         (ctrl_q[rtcot_pkg::CTRL_COARSE]),
    .add_i            (trim_q[rtcot_pkg::TRIM_SIGN]),
    .trim_magnitude_i (trim_q[rtcot_pkg::TRIM_MAG_HI:rtcot_pkg::TRIM_MAG_LO]),
    .prescale_o       (prescale),
    .sec_tick_o       (sec_tick_o),
    .trim_event_o     (trim_event_o)
  );

  // ==========================================================
  // pin source selection, open drain: oe pulls the pin low
  always_comb
  begin
    pin_level  = 1'b1;
    pin_driven = 1'b0;
    if (ctrl_q[rtcot_pkg::CTRL_SQW_EN])
    begin
      pin_driven = !on_backup_i;
      pin_level  = rtcot_sqw_level(
        ctrl_q[rtcot_pkg::CTRL_RATE_HI:rtcot_pkg::CTRL_RATE_LO],
        ctrl_q[rtcot_pkg::CTRL_COARSE], prescale, osc_level_i);
    end
    else if (ctrl_q[rtcot_pkg::CTRL_ALM0_EN] ||
             ctrl_q[rtcot_pkg::CTRL_ALM1_EN])
    begin
      pin_driven = 1'b1;
      pin_level  = rtcot_alarm_level(alarm_output_polarity_q,
        ctrl_q[rtcot_pkg::CTRL_ALM0_EN], ctrl_q[rtcot_pkg::CTRL_ALM1_EN],
        alarm_zero_flag_q, alarm_one_flag_q);
    end
    else
    begin
      pin_driven = !on_backup_i;
      pin_level  = ctrl_q[rtcot_pkg::CTRL_GPO_LVL];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      multi_function_pin_o    <= 1'b0;
      multi_function_pin_oe_o <= 1'b0;
    end
    else
    begin
      multi_function_pin_o    <= 1'b0;
      multi_function_pin_oe_o <= pin_driven && !pin_level;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic both_on;
  logic one0_on;
  logic gpo_mode;
  assign both_on = !ctrl_q[rtcot_pkg::CTRL_SQW_EN] &&
    ctrl_q[rtcot_pkg::CTRL_ALM0_EN] && ctrl_q[rtcot_pkg::CTRL_ALM1_EN];
  assign one0_on = !ctrl_q[rtcot_pkg::CTRL_SQW_EN] &&
    ctrl_q[rtcot_pkg::CTRL_ALM0_EN] && !ctrl_q[rtcot_pkg::CTRL_ALM1_EN];
  assign gpo_mode = !ctrl_q[rtcot_pkg::CTRL_SQW_EN] &&
    !ctrl_q[rtcot_pkg::CTRL_ALM0_EN] && !ctrl_q[rtcot_pkg::CTRL_ALM1_EN];

  a_dual_alarm_or: assert property (
    both_on && alarm_output_polarity_q |=>
    multi_function_pin_oe_o == !$past(alarm_zero_flag_q | alarm_one_flag_q))
    else $error("dual alarm or output wrong");
  a_dual_alarm_nand: assert property (
    both_on && !alarm_output_polarity_q |=>
    multi_function_pin_oe_o == $past(alarm_zero_flag_q & alarm_one_flag_q))
    else $error("dual alarm nand output wrong");
  a_single_alarm_pin: assert property (
    one0_on |=> multi_function_pin_oe_o ==
    ($past(alarm_output_polarity_q) ^ $past(alarm_zero_flag_q)))
    else $error("single alarm output wrong");
  a_gpo_level_pin: assert property (
    gpo_mode && !on_backup_i |=>
    multi_function_pin_oe_o == !$past(ctrl_q[rtcot_pkg::CTRL_GPO_LVL]))
    else $error("general purpose level wrong");
  a_gpo_backup_off: assert property (
    (gpo_mode && on_backup_i)[*2] |=> !multi_function_pin_oe_o)
    else $error("gpo driven on backup");
  a_sqw_backup_off: assert property (
    ctrl_q[rtcot_pkg::CTRL_SQW_EN] && on_backup_i |=>
    !multi_function_pin_oe_o)
    else $error("square wave driven on backup");
  a_trim_zero_none: assert property (
    trim_q[rtcot_pkg::TRIM_MAG_HI:rtcot_pkg::TRIM_MAG_LO] == 7'h00 |=>
    !trim_event_o)
    else $error("trim event with zero magnitude");
  a_flag_set_wins: assert property (
    alarm_zero_match_i |=> alarm_zero_flag_q)
    else $error("alarm flag set lost");
  a_pin_never_high: assert property (
    multi_function_pin_o == 1'b0)
    else $error("open drain pin driven high");
  a_add_advance: assert property (
    osc_tick_i && u_trim.apply && u_trim.add_i && !u_trim.wrap &&
    u_trim.swallow_q == 9'h000 |=>
    prescale == $past(prescale) + PW'(1) + PW'($past(u_trim.amount)))
    else $error("trim add amount wrong");

  c_dual_alarm: cover property (both_on && alarm_zero_flag_q &&
    alarm_one_flag_q);
  c_trim_add: cover property (trim_event_o && trim_q[rtcot_pkg::TRIM_SIGN]);
  c_trim_sub: cover property (trim_event_o && !trim_q[rtcot_pkg::TRIM_SIGN]);
  c_gpo_backup: cover property (gpo_mode && on_backup_i);

endmodule : rtcot_top

// [verification/rtcot_host.sv]
// host model driving the byte-wide register port
`timescale 1ns/10ps
module rtcot_host (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  initial
  begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // ==========================================================
  // register cycles
  // released address and data show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
    @(posedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge ref_clk_i);
    d = reg_rdata_i;
  endtask : rd
endmodule : rtcot_host

// [verification/rtc_output_select_and_trim_tb_top.sv]
// self-checking bench for output select and trim
`timescale 1ns/10ps
module rtc_output_select_and_trim_tb_top;
  localparam int PS  = 1024;
  localparam int SPM = 2;
  logic       ref_clk_i;
  logic       rst_n_i;
  logic       osc_tick_i;
  logic       osc_level_i;
  logic       on_backup_i;
  logic       m0;
  logic       m1;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       pin;
  logic       pin_oe;
  logic       sec_tick;
  logic       trim_ev;
  logic [7:0] v;
  logic       e;
  int         miscompares;
  int         checks;
  int         osc_n;
  int         osc_e;
  int         ev_n;
  int         ivq[$];
  int         fq[$];
  int         evq[$];

  rtcot_top #(
    .PRESCALE    (PS),
    .SEC_PER_MIN (SPM)
  ) u_rtcot_top (
    .ref_clk_i               (ref_clk_i),
    .rst_n_i                 (rst_n_i),
    .osc_tick_i              (osc_tick_i),
    .osc_level_i             (osc_level_i),
    .on_backup_i             (on_backup_i),
    .alarm_zero_match_i      (m0),
    .alarm_one_match_i       (m1),
    .reg_wr_i                (wr),
    .reg_rd_i                (rd),
    .reg_addr_i              (addr),
    .reg_wdata_i             (wdata),
    .reg_rdata_o             (rdata),
    .multi_function_pin_o    (pin),
    .multi_function_pin_oe_o (pin_oe),
    .sec_tick_o              (sec_tick),
    .trim_event_o            (trim_ev)
  );

  rtcot_host u_rtcot_host (
    .ref_clk_i   (ref_clk_i),
    .reg_rdata_i (rdata),
    .reg_wr_o    (wr),
    .reg_rd_o    (rd),
    .reg_addr_o  (addr),
    .reg_wdata_o (wdata)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // oscillator ticks and interval monitor
  always @(posedge ref_clk_i)
    osc_tick_i <= ~osc_tick_i;

  always @(posedge ref_clk_i)
  begin
    if (sec_tick === 1'b1)
    begin
      ivq.push_back(osc_n);
      fq.push_back(ev_n);
      osc_n = 0;
      ev_n  = 0;
    end
    if (trim_ev === 1'b1)
    begin
      evq.push_back(osc_e);
      osc_e = 0;
      ev_n++;
    end
    if (osc_tick_i === 1'b1)
    begin
      osc_n++;
      osc_e++;
    end
  end

  // ==========================================================
  // checking helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic wait_q(input int n, input bit use_ev);
    int k;
    k = 0;
    while ((use_ev ? evq.size() : ivq.size()) < n)
    begin
      @(posedge ref_clk_i);
      k++;
      if (k > 40000)
      begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask : wait_q

  // expected pull-down enable with square wave off
  function automatic logic exp_oe(int i);
    logic lv;
    if (i[0] && i[1])
      lv = i[2] ? (i[3] | i[4]) : ~(i[3] & i[4]);
    else if (i[0])
      lv = i[2] ? i[3] : ~i[3];
    else if (i[1])
      lv = i[2] ? i[4] : ~i[4];
    else if (i[6])
      return 1'b0;
    else
      lv = i[5];
    return ~lv;
  endfunction : exp_oe

  task automatic trim_run(input logic s, input int m, input logic bk);
    int x;
    int n;
    n = 0;
    on_backup_i <= bk;
    u_rtcot_host.wr(rtcot_pkg::ADDR_TRIM, {s, 7'(m)});
    u_rtcot_host.rd(rtcot_pkg::ADDR_TRIM, v);
    chk(v, {s, 7'(m)});
    ivq.delete();
    fq.delete();
    wait_q(7, 1'b0);
    for (int i = 1; i < 7; i++)
    begin
      x = (fq[i] == 0) ? PS : (s ? PS - 2 * m : PS + 2 * m);
      chk(ivq[i], x);
      n = n + fq[i];
    end
    chk(n, (m == 0) ? 0 : 6 / SPM);
  endtask : trim_run

  // counts pull-down changes of the square wave over n cycles
  task automatic sqw_run(input logic [7:0] c, input int n, input int x);
    int   tg;
    logic lo;
    tg = 0;
    u_rtcot_host.wr(rtcot_pkg::ADDR_CTRL, c);
    repeat (2) @(posedge ref_clk_i);
    lo = pin_oe;
    repeat (n)
    begin
      @(posedge ref_clk_i);
      if (pin_oe !== lo)
        tg++;
      lo = pin_oe;
    end
    chk(tg, x);
  endtask : sqw_run

  // ==========================================================
  // main sequence
  initial
  begin
    rst_n_i     = 1'b0;
    osc_tick_i  = 1'b0;
    osc_level_i = 1'b0;
    on_backup_i = 1'b0;
    m0          = 1'b0;
    m1          = 1'b0;
    miscompares = 0;
    checks      = 0;
    osc_n       = 0;
    osc_e       = 0;
    ev_n        = 0;
    void'($urandom(23146));
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    u_rtcot_host.wr(8'h20, 8'hff);
    for (int j = 0; j < 5; j++)
    begin
      u_rtcot_host.rd(j == 4 ? 8'h20 : (j == 3 ? 8'h14 :
                      (j == 2 ? 8'h0d : 8'(7 + j))), v);
      chk(v, 8'h00);
    end
    for (int i = 0; i < 128; i++)
    begin
      on_backup_i <= i[6];
      u_rtcot_host.wr(rtcot_pkg::ADDR_ALM0WD, {i[2], 3'h0, i[3], 3'h0});
      u_rtcot_host.wr(rtcot_pkg::ADDR_ALM1WD, {i[2], 3'h0, i[4], 3'h0});
      u_rtcot_host.wr(rtcot_pkg::ADDR_CTRL, {i[5], 1'b0, i[1:0], 4'h0});
      @(posedge ref_clk_i);
      e = exp_oe(i);
      chk({pin, pin_oe}, {1'b0, e});
    end
    // match pulses set the flags, alarm drive stays on backup
    u_rtcot_host.wr(rtcot_pkg::ADDR_ALM0WD, 8'h00);
    u_rtcot_host.wr(rtcot_pkg::ADDR_ALM1WD, 8'h00);
    u_rtcot_host.wr(rtcot_pkg::ADDR_CTRL, 8'h30);
    m0 <= 1'b1;
    m1 <= 1'b1;
    @(posedge ref_clk_i);
    m0 <= 1'b0;
    m1 <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(pin_oe, 1'b1);
    u_rtcot_host.rd(rtcot_pkg::ADDR_ALM1WD, v);
    chk(v, 8'h08);
    on_backup_i <= 1'b0;
    u_rtcot_host.wr(rtcot_pkg::ADDR_CTRL, 8'h73);
    osc_level_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(pin_oe, 1'b0);
    osc_level_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(pin_oe, 1'b1);
    on_backup_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(pin_oe, 1'b0);
    u_rtcot_host.wr(rtcot_pkg::ADDR_CTRL, 8'h00);
    trim_run(1'b1, $urandom_range(127, 1), 1'b0);
    trim_run(1'b0, 127, 1'b1);
    trim_run(1'b1, 0, 1'b0);
    // untrimmed square wave rates: two changes per output period
    sqw_run(8'h41, 320, 2 * 160 * 4096 / rtcot_pkg::OSC_HZ);
    sqw_run(8'h42, 320, 2 * 160 * 8192 / rtcot_pkg::OSC_HZ);
    sqw_run(8'h40, 4096, 2 * 2048 / PS);
    sqw_run(8'h44, 2048, 2 * 1024 * 64 / rtcot_pkg::OSC_HZ);
    u_rtcot_host.wr(rtcot_pkg::ADDR_CTRL, 8'h04);
    u_rtcot_host.wr(rtcot_pkg::ADDR_TRIM, 8'h81);
    evq.delete();
    wait_q(4, 1'b1);
    chk(evq[2], 256);
    chk(evq[3], 256);
    report_and_stop();
  end
endmodule : rtc_output_select_and_trim_tb_top
